// ===== bench/fault_monitor_status_led_bench.sv
// bench: random and corner scenarios for the fault monitor
module fault_monitor_status_led_bench;
	import fml_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------------------------------
	// shortened counts keep the run small
	// ----------------------------------------
	localparam int HBP = 100;
	localparam int HBB = 10;
	localparam int BP = 8;
	localparam int YH = 16;
	logic clock_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [7:0] temperature_i = 8'h00;
	fml_flt_t flt = '0;
	fml_flt_t f;
	logic step_i = 1'b0;
	logic motion_request_i = 1'b0;
	logic host_comm_i = 1'b0;
	logic system_fault_o, led_red_o, led_green_o, led_blue_o, irq_o;
	int error_cnt = 0;
	int n_compared = 0;
	int k, hi, tog, rl;
	logic [31:0] seed = 32'h84693BDD;
	logic [71:0] rep;
	logic prev;

	always #2 clock_i = ~clock_i;

	fml_host u_fml_host (.clock_i(clock_i), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite),
		.paddr_o(paddr), .pwdata_o(pwdata), .prdata_i(prdata), .pready_i(pready), .pslverr_i(pslverr));

	fml_fault_monitor #(.HB_PERIOD(HBP), .HB_BURST(HBB), .IDLE_TIME(40), .BLUE_PULSE(BP), .YEL_HALF(YH))
	u_fml_fault_monitor (.clock_i(clock_i), .reset_n_i(reset_n_i), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
		.pslverr_o(pslverr), .fuse_open_i(flt.fuse), .motor_supply_voltage_over_i(flt.motor_over),
		.io_reference_voltage_over_i(flt.io_over), .overcurrent_i(flt.ocur), .temperature_i(temperature_i),
		.step_i(step_i), .motion_request_i(motion_request_i), .host_comm_i(host_comm_i),
		.system_fault_o(system_fault_o), .led_red_o(led_red_o), .led_green_o(led_green_o),
		.led_blue_o(led_blue_o), .irq_o(irq_o));

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	function automatic logic [71:0] exp_reply(input logic [4:0] v);
		logic [7:0] c [5] = '{CH_FUSE, CH_TEMP, CH_MOTOR, CH_IO, CH_OCUR};
		logic [71:0] r;
		r = '0;
		for (int i = 0; i < 5; i++) begin
			r[i*16 +: 8] = v[4-i] ? c[i] : CH_DASH;
			if (i < 4) r[i*16+8 +: 8] = CH_SLASH;
		end
		return r;
	endfunction

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic err = 1'b0);
		logic [31:0] q;
		logic e;
		u_fml_host.xfer(1'b0, a, 32'h0, q, e);
		chk(q, exp);
		chk({31'h0, e}, {31'h0, err});
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		u_fml_host.xfer(1'b1, a, d, q, e);
		chk({31'h0, e}, 32'h0);
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clock_i);
	endtask

	// green high cycles and toggles, cycles with red off
	task automatic watch(input int n);
		hi = 0;
		tog = 0;
		rl = 0;
		@(posedge clock_i);
		#1 prev = led_green_o;
		repeat (n) begin
			@(posedge clock_i);
			#1;
			hi += int'(led_green_o === 1'b1);
			tog += int'(led_green_o !== prev);
			rl += int'(led_red_o !== 1'b1);
			prev = led_green_o;
		end
	endtask

	task automatic stop_test();
		if (error_cnt == 0 && n_compared > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	initial begin
		tick(16);
		reset_n_i <= 1'b1;
		tick(4);
		watch(HBP);
		chk(hi, HBB);
		chk(rl, HBP);
		tick(1);
		for (k = 0; k < 20; k++) begin
			if (k == 4) fork watch(64); join_none
			step_i <= 1'b1;
			tick(2);
			step_i <= 1'b0;
			tick(2);
		end
		wait fork;
		chk(tog, 16 / (1 << (STEP_DIV_W - 1)));
		wr(ADDR_CTRL, 32'h1);
		rd(ADDR_CTRL, 32'h1);
		rd(8'h24, 32'h0, 1'b1);
		wr(ADDR_FAULT, 32'h1F);
		// single faults first, then random mixes; temperature sits within 4 of the limit, either side
		for (k = 0; k < 16; k++) begin
			seed = lfsr(seed);
			f = (k < 5) ? fml_flt_t'(5'h10 >> k) : fml_flt_t'(seed[4:0]);
			tick(1);
			flt <= f;
			temperature_i <= f.temp ? 8'h65 + seed[7:6] : 8'h64 - seed[7:6];
			tick(10);
			#1 chk({28'h0, led_red_o, led_green_o & |f, led_blue_o, system_fault_o}, {28'h0, |f, 1'b0, ~|f, |f});
			rep = exp_reply(f);
			rd(ADDR_FAULT, {27'h0, f});
			rd(ADDR_REPLY0, rep[31:0]);
			rd(ADDR_REPLY1, rep[63:32]);
			rd(ADDR_REPLY2, {24'h0, rep[71:64]});
			if (|f) rd(ADDR_LED, 32'h4);
		end
		tick(1);
		flt <= 5'h01;
		temperature_i <= 8'h20;
		motion_request_i <= 1'b1;
		tick(10);
		watch(64);
		chk(tog, 64 / YH);
		chk(rl, 0);
		tick(1);
		flt <= '0;
		motion_request_i <= 1'b0;
		tick(10);
		wr(ADDR_IRQ_CLEAR, 32'h3F);
		rd(ADDR_IRQ_STATUS, 32'h0);
		wr(ADDR_IRQ_ENABLE, 32'h01);
		tick(1);
		flt <= 5'h10;
		tick(10);
		rd(ADDR_IRQ_STATUS, 32'h10);
		#1 chk({31'h0, irq_o}, 32'h0);
		wr(ADDR_IRQ_ENABLE, 32'h10);
		rd(ADDR_IRQ_ENABLE, 32'h10);
		#1 chk({31'h0, irq_o}, 32'h1);
		tick(1);
		flt <= '0;
		tick(10);
		rd(ADDR_IRQ_STATUS, 32'h30);
		wr(ADDR_IRQ_CLEAR, 32'h10);
		rd(ADDR_IRQ_STATUS, 32'h20);
		rd(ADDR_IRQ_CLEAR, 32'h0);
		#1 chk({31'h0, irq_o}, 32'h0);
		wr(ADDR_CTRL, 32'h0);
		tick(1);
		host_comm_i <= 1'b1;
		tick(1);
		host_comm_i <= 1'b0;
		tick(3);
		#1 chk({31'h0, led_blue_o}, 32'h1);
		tick(BP + 4);
		#1 chk({31'h0, led_blue_o}, 32'h0);
		stop_test();
	end

	// run should need about 800 cycles
	initial begin
		tick(6000);
		error_cnt++;
		stop_test();
	end
endmodule // fault_monitor_status_led_bench

// ===== bench/fml_host.sv
// host model: APB master issuing register accesses and fault queries
module fml_host
	import fml_pkg::*;
(
	input wire logic clock_i,
	output logic psel_o,
	output logic penable_o,
	output logic pwrite_o,
	output logic [7:0] paddr_o,
	output logic [31:0] pwdata_o,
	input wire logic [31:0] prdata_i,
	input wire logic pready_i,
	input wire logic pslverr_i
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		psel_o = 1'b0;
		penable_o = 1'b0;
		pwrite_o = 1'b0;
		paddr_o = 8'h00;
		pwdata_o = 32'h0;
	end

	// ----------------------------------------
	// one transfer; a query may come at any time
	// ----------------------------------------
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		@(posedge clock_i);
		psel_o <= 1'b1;
		penable_o <= 1'b0;
		pwrite_o <= w;
		paddr_o <= a;
		pwdata_o <= d;
		@(posedge clock_i);
		penable_o <= 1'b1;
		@(posedge clock_i);
		while (pready_i !== 1'b1) @(posedge clock_i);
		q = prdata_i;
		e = pslverr_i;
		psel_o <= 1'b0;
		penable_o <= 1'b0;
		// released lines flip so stale values never look valid
		paddr_o <= ~a;
		pwdata_o <= ~d;
	endtask
endmodule // fml_host

// ===== design/fml_fault_monitor.sv
// fault supervision, fault reply and status indicator, reached over APB
module fml_fault_monitor
	import fml_pkg::*;
#(
	parameter int unsigned HB_PERIOD = HB_PERIOD_CYC,
	parameter int unsigned HB_BURST = HB_BURST_CYC,
	parameter int unsigned IDLE_TIME = IDLE_CYC,
	parameter int unsigned BLUE_PULSE = BLUE_PULSE_CYC,
	parameter int unsigned YEL_HALF = YEL_HALF_CYC
) (
	input wire logic clock_i,
	input wire logic reset_n_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic fuse_open_i,
	input wire logic motor_supply_voltage_over_i,
	input wire logic io_reference_voltage_over_i,
	input wire logic overcurrent_i,
	input wire logic [7:0] temperature_i,
	input wire logic step_i,
	input wire logic motion_request_i,
	input wire logic host_comm_i,
	output logic system_fault_o,
	output logic led_red_o,
	output logic led_green_o,
	output logic led_blue_o,
	output logic irq_o
);

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic [4:0] pin_s1;
	logic [4:0] pin_s2;
	logic step_d;

	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			pin_s1 <= 5'h00;
			pin_s2 <= 5'h00;
		end else begin
			pin_s1 <= {fuse_open_i, motor_supply_voltage_over_i, io_reference_voltage_over_i,
				overcurrent_i, step_i};
			pin_s2 <= pin_s1;
		end
	end

	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			step_d <= 1'b0;
		end else begin
			step_d <= pin_s2[0];
		end
	end

	logic step_evt;
	assign step_evt = pin_s2[0] & ~step_d;

	// ----------------------------------------
	// fault flags
	// ----------------------------------------
	fml_flt_t flt;
	fml_flt_t flt_d;
	logic sys_fault;

	// sampled every cycle, never latched: the flags follow the live condition
	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			flt <= '0;
		end else begin
			flt.fuse <= pin_s2[4];
			flt.temp <= (temperature_i > TEMP_MAX_C);
			flt.motor_over <= pin_s2[3];
			flt.io_over <= pin_s2[2];
			flt.ocur <= pin_s2[1];
		end
	end

	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			sys_fault <= 1'b0;
			flt_d <= '0;
		end else begin
			sys_fault <= |flt;
			flt_d <= flt;
		end
	end

	assign system_fault_o = sys_fault;

	// ----------------------------------------
	// register file
	// ----------------------------------------
	logic prog_mode;
	logic [IRQ_W-1:0] irq_status;
	logic [IRQ_W-1:0] irq_enable;
	logic [IRQ_W-1:0] irq_set;
	logic [IRQ_W-1:0] irq_clr;
	logic [71:0] reply;
	logic setup;
	logic access;
	logic wr;
	logic hit;
	logic [31:0] next_rdata;
	fml_led_t led;

	assign setup = psel_i & ~penable_i;
	assign access = psel_i & penable_i;
	assign reply = fml_reply(flt);

	always_comb begin
		hit = 1'b1;
		next_rdata = 32'h0000_0000;
		if (paddr_i == ADDR_CTRL) begin
			next_rdata[CTRL_PROG_BIT] = prog_mode;
		end else if (paddr_i == ADDR_FAULT) begin
			next_rdata[4:0] = flt;
		end else if (paddr_i == ADDR_REPLY0) begin
			next_rdata = reply[31:0];
		end else if (paddr_i == ADDR_REPLY1) begin
			next_rdata = reply[63:32];
		end else if (paddr_i == ADDR_REPLY2) begin
			next_rdata[7:0] = reply[71:64];
		end else if (paddr_i == ADDR_IRQ_STATUS) begin
			next_rdata[IRQ_W-1:0] = irq_status;
		end else if (paddr_i == ADDR_IRQ_CLEAR) begin
			next_rdata = 32'h0000_0000;
		end else if (paddr_i == ADDR_IRQ_ENABLE) begin
			next_rdata[IRQ_W-1:0] = irq_enable;
		end else if (paddr_i == ADDR_LED) begin
			next_rdata[2:0] = led;
		end else begin
			hit = 1'b0;
		end
	end

	// zero wait states: read data is captured in the setup cycle
	assign pready_o = access;
	assign pslverr_o = access & ~hit;
	assign wr = access & pwrite_i & hit;

	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			prdata_o <= 32'h0000_0000;
		end else if (setup) begin
			prdata_o <= pwrite_i ? 32'h0000_0000 : next_rdata;
		end
	end

	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			prog_mode <= CTRL_RESET;
		end else if (wr && paddr_i == ADDR_CTRL) begin
			prog_mode <= pwdata_i[CTRL_PROG_BIT];
		end
	end

	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			irq_enable <= IRQ_RESET;
		end else if (wr && paddr_i == ADDR_IRQ_ENABLE) begin
			irq_enable <= pwdata_i[IRQ_W-1:0];
		end
	end

	// ----------------------------------------
	// interrupts
	// ----------------------------------------
	assign irq_set = {(|flt_d) & ~(|flt), flt & ~flt_d};
	assign irq_clr = (wr && paddr_i == ADDR_IRQ_CLEAR) ? pwdata_i[IRQ_W-1:0] : IRQ_RESET;

	// a new event in the clearing cycle survives
	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			irq_status <= IRQ_RESET;
		end else begin
			irq_status <= (irq_status & ~irq_clr) | irq_set;
		end
	end

	assign irq_o = |(irq_status & irq_enable);

	// ----------------------------------------
	// indicator timing
	// ----------------------------------------
	logic [31:0] hb_cnt;
	logic [31:0] idle_cnt;
	logic [31:0] blue_cnt;
	logic [31:0] yel_cnt;
	logic yel_phase;
	logic [STEP_DIV_W-1:0] step_div;
	logic moving;

	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			hb_cnt <= 32'h0000_0000;
		end else if (hb_cnt >= HB_PERIOD - 1) begin
			hb_cnt <= 32'h0000_0000;
		end else begin
			hb_cnt <= hb_cnt + 32'h0000_0001;
		end
	end

	// faster stepping toggles the top bit sooner
	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			step_div <= '0;
		end else if (step_evt) begin
			step_div <= step_div + 1'b1;
		end
	end

	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			idle_cnt <= IDLE_TIME;
		end else if (step_evt) begin
			idle_cnt <= 32'h0000_0000;
		end else if (idle_cnt < IDLE_TIME) begin
			idle_cnt <= idle_cnt + 32'h0000_0001;
		end
	end

	assign moving = (idle_cnt < IDLE_TIME);

	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			blue_cnt <= 32'h0000_0000;
		end else if (host_comm_i) begin
			blue_cnt <= BLUE_PULSE;
		end else if (blue_cnt != 32'h0000_0000) begin
			blue_cnt <= blue_cnt - 32'h0000_0001;
		end
	end

	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			yel_cnt <= 32'h0000_0000;
			yel_phase <= 1'b0;
		end else if (yel_cnt >= YEL_HALF - 1) begin
			yel_cnt <= 32'h0000_0000;
			yel_phase <= ~yel_phase;
		end else begin
			yel_cnt <= yel_cnt + 32'h0000_0001;
		end
	end

	// ----------------------------------------
	// indicator state machine
	// ----------------------------------------
	fml_state_t state;
	fml_state_t next_state;
	fml_led_t next_led;

	always_comb begin
		case ({sys_fault, motion_request_i})
			2'b10: next_state = ST_FLT_STEADY;
			2'b11: next_state = ST_FLT_MOTION;
			default: next_state = ST_NORMAL;
		endcase
	end

	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			state <= ST_NORMAL;
		end else begin
			state <= next_state;
		end
	end

	always_comb begin
		next_led = '0;
		case (state)
			ST_FLT_STEADY: begin
				next_led.red = 1'b1;
			end
			ST_FLT_MOTION: begin
				next_led.red = 1'b1;
				next_led.green = yel_phase;
			end
			default: begin
				next_led.green = moving ? step_div[STEP_DIV_W-1] : (hb_cnt < HB_BURST);
				next_led.blue = prog_mode | (blue_cnt != 32'h0000_0000);
			end
		endcase
	end

	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			led <= '0;
		end else begin
			led <= next_led;
		end
	end

	assign led_red_o = led.red;
	assign led_green_o = led.green;
	assign led_blue_o = led.blue;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	a_fault_aggregate: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		(flt != 5'h00) |=> sys_fault)
		else $error("system fault not raised");

	a_fault_clear: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		(flt == 5'h00) |=> !sys_fault)
		else $error("system fault raised without cause");

	a_fuse_flag: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		fuse_open_i [*3] |=> flt.fuse)
		else $error("fuse flag missing");

	a_temp_flag: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		##1 flt.temp == ($past(temperature_i) > TEMP_MAX_C))
		else $error("overtemp flag wrong");

	a_motor_flag: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		motor_supply_voltage_over_i [*3] |=> flt.motor_over)
		else $error("motor supply flag missing");

	a_io_flag: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		io_reference_voltage_over_i [*3] |=> flt.io_over)
		else $error("io reference flag missing");

	a_ocur_flag: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		overcurrent_i [*3] |=> flt.ocur)
		else $error("overcurrent flag missing");

	a_reply_fuse: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		(setup && !pwrite_i && paddr_i == ADDR_REPLY0) |=>
		prdata_o[7:0] == ($past(flt.fuse) ? CH_FUSE : CH_DASH) && prdata_o[15:8] == CH_SLASH)
		else $error("reply field wrong");

	a_reply_live: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		(setup && !pwrite_i && paddr_i == ADDR_FAULT) |=> prdata_o[4:0] == $past(flt))
		else $error("live fault read wrong");

	a_fault_red: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		sys_fault |=> ##1 led.red && !led.blue)
		else $error("fault not shown red");

	a_steady_red: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		(state == ST_FLT_STEADY) |=> led.red && !led.green && !led.blue)
		else $error("steady red broken");

	a_yellow_flash: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		(state == ST_FLT_MOTION) |=> led.red && led.green == $past(yel_phase))
		else $error("yellow flash broken");

	a_no_fault_blue: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		(state != ST_NORMAL) |=> !led.blue)
		else $error("mode shown during fault");

	a_prog_blue: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		(state == ST_NORMAL && prog_mode) |=> led.blue)
		else $error("program mode not blue");

	a_comm_blue: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		(host_comm_i && next_state == ST_NORMAL) |=> ##1 led.blue || state != ST_NORMAL)
		else $error("traffic not shown blue");

	a_idle_burst: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		(state == ST_NORMAL && !moving) |=> led.green == ($past(hb_cnt) < HB_BURST))
		else $error("idle burst wrong");

	a_step_divide: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		step_evt |=> step_div == $past(step_div) + 1'b1)
		else $error("step divider stalled");

	a_hb_wrap: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		(hb_cnt >= HB_PERIOD - 1) |=> hb_cnt == 32'h0000_0000)
		else $error("heartbeat counter wrap wrong");

	a_irq_sticky: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		(irq_status[0] && irq_clr[0] == 1'b0) |=> irq_status[0])
		else $error("status bit lost");

endmodule // fml_fault_monitor

// ===== design/fml_pkg.sv
// package: register map, fault layout, reply characters and timing for the fault monitor
package fml_pkg;

	// ----------------------------------------
	// clock and timing
	// ----------------------------------------
	localparam int unsigned CLK_HZ = 250_000_000;
	localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
	localparam int unsigned HB_PERIOD_MS = 1000;
	localparam int unsigned HB_BURST_MS = 50;
	localparam int unsigned IDLE_MS = 100;
	localparam int unsigned BLUE_PULSE_MS = 20;
	localparam int unsigned YEL_HALF_MS = 250;
	localparam int unsigned HB_PERIOD_CYC = HB_PERIOD_MS * CYC_PER_MS;
	localparam int unsigned HB_BURST_CYC = HB_BURST_MS * CYC_PER_MS;
	localparam int unsigned IDLE_CYC = IDLE_MS * CYC_PER_MS;
	localparam int unsigned BLUE_PULSE_CYC = BLUE_PULSE_MS * CYC_PER_MS;
	localparam int unsigned YEL_HALF_CYC = YEL_HALF_MS * CYC_PER_MS;
	localparam int unsigned STEP_DIV_W = 4;

	// ----------------------------------------
	// fault thresholds
	// ----------------------------------------
	localparam logic [7:0] TEMP_MAX_C = 8'h64;

	// ----------------------------------------
	// register byte addresses
	// ----------------------------------------
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_FAULT = 8'h04;
	localparam logic [7:0] ADDR_REPLY0 = 8'h08;
	localparam logic [7:0] ADDR_REPLY1 = 8'h0C;
	localparam logic [7:0] ADDR_REPLY2 = 8'h10;
	localparam logic [7:0] ADDR_IRQ_STATUS = 8'h14;
	localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h18;
	localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h1C;
	localparam logic [7:0] ADDR_LED = 8'h20;

	localparam int unsigned CTRL_PROG_BIT = 0;
	localparam logic CTRL_RESET = 1'h0;
	localparam int unsigned IRQ_W = 6;
	localparam int unsigned IRQ_CLEARED_BIT = 5;
	localparam logic [IRQ_W-1:0] IRQ_RESET = 6'h00;

	// ----------------------------------------
	// reply characters
	// ----------------------------------------
	localparam logic [7:0] CH_FUSE = 8'h46;
	localparam logic [7:0] CH_TEMP = 8'h54;
	localparam logic [7:0] CH_MOTOR = 8'h56;
	localparam logic [7:0] CH_IO = 8'h49;
	localparam logic [7:0] CH_OCUR = 8'h43;
	localparam logic [7:0] CH_DASH = 8'h2D;
	localparam logic [7:0] CH_SLASH = 8'h2F;

	// ----------------------------------------
	// carriers
	// ----------------------------------------
	typedef struct packed {
		logic fuse;
		logic temp;
		logic motor_over;
		logic io_over;
		logic ocur;
	} fml_flt_t;

	typedef struct packed {
		logic red;
		logic green;
		logic blue;
	} fml_led_t;

	typedef enum logic [2:0] {
		ST_NORMAL = 3'h1,
		ST_FLT_STEADY = 3'h2,
		ST_FLT_MOTION = 3'h4
	} fml_state_t;

	// nine characters, first one in the low byte
	function automatic logic [71:0] fml_reply(input fml_flt_t f);
		fml_reply = {f.ocur ? CH_OCUR : CH_DASH, CH_SLASH,
			f.io_over ? CH_IO : CH_DASH, CH_SLASH,
			f.motor_over ? CH_MOTOR : CH_DASH, CH_SLASH,
			f.temp ? CH_TEMP : CH_DASH, CH_SLASH,
			f.fuse ? CH_FUSE : CH_DASH};
	endfunction

endpackage
